//--- src/board_info_register_bank.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
// What this block does
// - Swap control register at 0x00, read/write, resets to zero.
// - Swap output high when any swap bit set, low only when all zero.
// - Indicator lamp control register, read/write, at 0x04.
// - Lamp bit 0: zero off, one on, reset zero; upper bits reserved.
// - Health lamp control register at 0x08 picks alarms lighting the lamp.
// - Low four bits are alarm enables resetting to zero; rest reserved.
// - Bit 3 gates auxiliary rail alarm, bit 2 the core rail alarm.
// - Bit 1 gates user temperature alarm, bit 0 over-temperature alarm.
// - Board type status word, read-only, at 0x0C.
// - Image type status word, read-only, at 0x10.
// - Image revision status word, read-only, at 0x14.
// - Image revision date status word, read-only, at 0x18.
// - Front panel I/O identification word, read-only, at 0x1C.
// - User-defined status word, read-only, at 0x20.
// - Serial host link state word, read-only, at 0x24.
// - Interrupt source status at 0x2C shows current source levels.
// - Swap output is active high.
// - Indicator lamp drive is active low.
// - Health lamp drive goes low on an enabled temperature or supply alarm.
module board_info_register_bank
  import board_info_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire status_words_s statusWords,
  input  wire logic          auxRailAlarm,
  input  wire logic          coreRailAlarm,
  input  wire logic          userTempAlarm,
  input  wire logic          overTempAlarm,
  input  wire logic [15:0]   irqSources,
  output logic               swapOut,
  output logic               lampDriveN,
  output logic               healthLampN
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] strobeMerge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Used by the write error decode; reads decode their own map
  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= IRQ_LATCHED_FLAGS_OFS);
  endfunction

  bank_state_s stateReg;
  bank_state_s stateNext;
  logic [3:0]  alarmVec;
  logic        setupPhase;
  logic        wrHit;
  logic        rdHit;
  logic        accessWr;
  logic [15:0] irqRise;
  logic [31:0] mergeWord;

  assign alarmVec[AUX_RAIL_BIT]  = auxRailAlarm;
  assign alarmVec[CORE_RAIL_BIT] = coreRailAlarm;
  assign alarmVec[USER_TEMP_BIT] = userTempAlarm;
  assign alarmVec[OVER_TEMP_BIT] = overTempAlarm;

  // Answer one cycle after setup: access phase always sees pready
  assign setupPhase = psel && !penable;
  assign wrHit      = setupPhase && pwrite;
  assign rdHit      = setupPhase && !pwrite;
  // Writes land only at the edge where the master sees pready
  assign accessWr   = psel && penable && pwrite && stateReg.pready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    stateNext = stateReg;
    mergeWord = ZERO_WORD;
    irqRise   = irqSources & ~stateReg.irqSourcePrev;
    stateNext.irqSourcePrev = irqSources;
    stateNext.pready  = setupPhase;
    stateNext.pslverr = 1'b0;
    if (!rdHit) begin
      stateNext.prdata = ZERO_WORD;
    end
    if (wrHit && !isMapped(paddr)) begin
      stateNext.pslverr = 1'b1;
    end
    if (accessWr) begin
      unique case (paddr)
        SWAP_ORDER_CTRL_OFS: begin
          stateNext.swapOrderCtrl = strobeMerge(stateReg.swapOrderCtrl, pwdata, pstrb);
        end
        INDICATOR_LAMP_CTRL_OFS: begin
          if (pstrb[0]) begin
            stateNext.lampOn = pwdata[LAMP_ON_BIT];
          end
        end
        HEALTH_LAMP_SOURCE_CTRL_OFS: begin
          if (pstrb[0]) begin
            stateNext.healthAlarmEnables = pwdata[ALARM_W-1:0];
          end
        end
        IRQ_ENABLE_MASK_OFS: begin
          mergeWord = strobeMerge({16'h0000, stateReg.irqEnableMask}, pwdata, pstrb);
          stateNext.irqEnableMask = mergeWord[IRQ_W-1:0];
        end
        BOARD_TYPE_STAT_OFS, IMAGE_TYPE_STAT_OFS, IMAGE_REVISION_STAT_OFS,
        IMAGE_REVISION_DATE_STAT_OFS, PANEL_IO_IDENT_STAT_OFS, USER_WORD_STAT_OFS,
        HOST_LINK_STATE_OFS, IRQ_SOURCE_STATE_OFS, IRQ_LATCHED_FLAGS_OFS: begin
          // Writes to read-only words are ignored without error
        end
        default: begin
          // Unmapped: error already flagged at setup
        end
      endcase
    end
    if (rdHit) begin
      unique case (paddr)
        SWAP_ORDER_CTRL_OFS:          stateNext.prdata = stateReg.swapOrderCtrl;
        INDICATOR_LAMP_CTRL_OFS:      stateNext.prdata = {31'h0000_0000, stateReg.lampOn};
        HEALTH_LAMP_SOURCE_CTRL_OFS:  stateNext.prdata = {28'h000_0000,
                                                          stateReg.healthAlarmEnables};
        BOARD_TYPE_STAT_OFS:          stateNext.prdata = statusWords.boardType;
        IMAGE_TYPE_STAT_OFS:          stateNext.prdata = statusWords.imageType;
        IMAGE_REVISION_STAT_OFS:      stateNext.prdata = statusWords.imageRevision;
        IMAGE_REVISION_DATE_STAT_OFS: stateNext.prdata = statusWords.imageRevisionDate;
        PANEL_IO_IDENT_STAT_OFS:      stateNext.prdata = statusWords.panelIoIdent;
        USER_WORD_STAT_OFS:           stateNext.prdata = statusWords.userWord;
        HOST_LINK_STATE_OFS:          stateNext.prdata = statusWords.hostLinkState;
        IRQ_ENABLE_MASK_OFS:          stateNext.prdata = {16'h0000, stateReg.irqEnableMask};
        IRQ_SOURCE_STATE_OFS:         stateNext.prdata = {16'h0000, irqSources};
        IRQ_LATCHED_FLAGS_OFS:        stateNext.prdata = {16'h0000, stateReg.irqLatchedFlags};
        default: begin
          stateNext.prdata  = ZERO_WORD;
          stateNext.pslverr = 1'b1;
        end
      endcase
    end
    // Read clears flags; a new event in the same cycle wins over the clear
    if (rdHit && paddr == IRQ_LATCHED_FLAGS_OFS) begin
      stateNext.irqLatchedFlags = IRQ_EN_RST;
    end
    stateNext.irqLatchedFlags = stateNext.irqLatchedFlags
                              | (irqRise & stateReg.irqEnableMask);
    stateNext.swapOut     = |stateNext.swapOrderCtrl;
    stateNext.lampDriveN  = ~stateNext.lampOn;
    stateNext.healthLampN = ~|(alarmVec & stateNext.healthAlarmEnables);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stateReg <= '{swapOrderCtrl: SWAP_RST, lampOn: LAMP_RST,
                    healthAlarmEnables: ALARM_EN_RST, irqEnableMask: IRQ_EN_RST,
                    irqSourcePrev: IRQ_EN_RST, irqLatchedFlags: IRQ_EN_RST,
                    prdata: ZERO_WORD, pready: 1'b0, pslverr: 1'b0,
                    swapOut: 1'b0, lampDriveN: 1'b1, healthLampN: 1'b1};
    end else begin
      stateReg <= stateNext;
    end
  end

  assign prdata      = stateReg.prdata;
  assign pready      = stateReg.pready;
  assign pslverr     = stateReg.pslverr;
  assign swapOut     = stateReg.swapOut;
  assign lampDriveN  = stateReg.lampDriveN;
  assign healthLampN = stateReg.healthLampN;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence swapWriteS;
    accessWr && paddr == SWAP_ORDER_CTRL_OFS && pstrb == 4'hF;
  endsequence

  swap_reset_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> !swapOut) else $error("swap not low after reset");
  swap_any_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    swapWriteS |=> (swapOut == ($past(pwdata) != ZERO_WORD)) [*1])
    else $error("swap output does not follow written word");
  swap_level_a: assert property (@(posedge clk) disable iff (!nrst)
    swapOut == (stateReg.swapOrderCtrl != ZERO_WORD))
    else $error("swap output mismatch");
  lamp_drive_low_a: assert property (@(posedge clk) disable iff (!nrst)
    accessWr && paddr == INDICATOR_LAMP_CTRL_OFS && pstrb[0]
    |=> lampDriveN == !$past(pwdata[LAMP_ON_BIT]))
    else $error("lamp drive wrong after write");
  lamp_read_back_a: assert property (@(posedge clk) disable iff (!nrst)
    rdHit && paddr == INDICATOR_LAMP_CTRL_OFS
    |=> prdata == {31'h0000_0000, !lampDriveN})
    else $error("lamp readback mismatch");
  health_lamp_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 healthLampN == !(|($past(alarmVec) & stateReg.healthAlarmEnables)))
    else $error("health lamp mismatch");
  aux_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    auxRailAlarm && stateNext.healthAlarmEnables[AUX_RAIL_BIT] |=> !healthLampN)
    else $error("aux rail alarm not shown");
  over_temp_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    overTempAlarm && stateNext.healthAlarmEnables[OVER_TEMP_BIT] |=> !healthLampN)
    else $error("over-temp alarm not shown");
  health_reserved_a: assert property (@(posedge clk) disable iff (!nrst)
    rdHit && paddr == HEALTH_LAMP_SOURCE_CTRL_OFS |=> prdata[31:4] == 28'h000_0000)
    else $error("health reserved bits nonzero");
  flag_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    |(irqRise & stateReg.irqEnableMask) |=> |stateReg.irqLatchedFlags [*1])
    else $error("enabled event not latched");
  source_read_a: assert property (@(posedge clk) disable iff (!nrst)
    rdHit && paddr == IRQ_SOURCE_STATE_OFS |=> prdata[15:0] == $past(irqSources))
    else $error("source state readback mismatch");
  ready_one_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    setupPhase |=> pready ##1 !pready)
    else $error("pready timing wrong");

endmodule

//--- src/board_info_pkg.sv
package board_info_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SWAP_ORDER_CTRL_OFS          = 8'h00;
  localparam logic [7:0] INDICATOR_LAMP_CTRL_OFS      = 8'h04;
  localparam logic [7:0] HEALTH_LAMP_SOURCE_CTRL_OFS  = 8'h08;
  localparam logic [7:0] BOARD_TYPE_STAT_OFS          = 8'h0C;
  localparam logic [7:0] IMAGE_TYPE_STAT_OFS          = 8'h10;
  localparam logic [7:0] IMAGE_REVISION_STAT_OFS      = 8'h14;
  localparam logic [7:0] IMAGE_REVISION_DATE_STAT_OFS = 8'h18;
  localparam logic [7:0] PANEL_IO_IDENT_STAT_OFS      = 8'h1C;
  localparam logic [7:0] USER_WORD_STAT_OFS           = 8'h20;
  localparam logic [7:0] HOST_LINK_STATE_OFS          = 8'h24;
  localparam logic [7:0] IRQ_ENABLE_MASK_OFS          = 8'h28;
  localparam logic [7:0] IRQ_SOURCE_STATE_OFS         = 8'h2C;
  localparam logic [7:0] IRQ_LATCHED_FLAGS_OFS        = 8'h30;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          LAMP_ON_BIT       = 0;
  localparam int          ALARM_W           = 4;
  localparam int          AUX_RAIL_BIT      = 3;
  localparam int          CORE_RAIL_BIT     = 2;
  localparam int          USER_TEMP_BIT     = 1;
  localparam int          OVER_TEMP_BIT     = 0;
  localparam int          IRQ_W             = 16;
  localparam logic [31:0] SWAP_RST          = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;
  localparam logic        LAMP_RST          = 1'b0;
  localparam logic [3:0]  ALARM_EN_RST      = 4'h0;
  localparam logic [15:0] IRQ_EN_RST        = 16'h0000;

  // ----------------------------------------------------------------
  // State carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] swapOrderCtrl;
    logic        lampOn;
    logic [3:0]  healthAlarmEnables;
    logic [15:0] irqEnableMask;
    logic [15:0] irqSourcePrev;
    logic [15:0] irqLatchedFlags;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        swapOut;
    logic        lampDriveN;
    logic        healthLampN;
  } bank_state_s;

  typedef struct packed {
    logic [31:0] boardType;
    logic [31:0] imageType;
    logic [31:0] imageRevision;
    logic [31:0] imageRevisionDate;
    logic [31:0] panelIoIdent;
    logic [31:0] userWord;
    logic [31:0] hostLinkState;
  } status_words_s;

endpackage

//--- verif/apb_host_model.sv
`timescale 1ns/1ps
module apb_host_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic timedOut;
  initial begin
    {psel, penable, pwrite, timedOut} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
  end
  // An edge always passes first, so a release never meets a new setup
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) timedOut = 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look stable
    pwdata <= ~d;
  endtask
endmodule

//--- verif/board_info_register_bank_test.sv
`timescale 1ns/1ps
module board_info_register_bank_test;
  import board_info_pkg::*;
  logic          clk, nrst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdat;
  logic [3:0]    pstrb;
  status_words_s statusWords;
  logic          auxRailAlarm, coreRailAlarm, userTempAlarm, overTempAlarm;
  logic [15:0]   irqSources;
  logic          swapOut, lampDriveN, healthLampN;
  logic [31:0]   stat [7];
  int            numErrors, cmpCount;

  apb_host_model apb_host_model_i (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr);
  board_info_register_bank board_info_register_bank_i (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .statusWords,
    .auxRailAlarm, .coreRailAlarm, .userTempAlarm, .overTempAlarm, .irqSources,
    .swapOut, .lampDriveN, .healthLampN);

  always #5 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_host_model_i.xfer(wr, a, d, rdat, rerr);
    if (apb_host_model_i.timedOut) begin
      numErrors++;
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eErr);
    acc(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, eErr});
  endtask
  task automatic pins(input logic s, input logic l, input logic h);
    repeat (2) @(posedge clk);
    chk({29'h0, swapOut, lampDriveN, healthLampN}, {29'h0, s, l, h});
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {auxRailAlarm, coreRailAlarm, userTempAlarm, overTempAlarm} = 4'h0;
    irqSources = 16'h0000;
    // Arbitrary status contents
    stat = '{32'h0007_FFF0, 32'h000A_BCDE, 32'h1234_5678, 32'h0012_3456,
             32'h0F0F_0F0F, 32'hCAFE_F00D, 32'h0000_0013};
    statusWords = {stat[0], stat[1], stat[2], stat[3], stat[4], stat[5], stat[6]};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    pins(1'b0, 1'b1, 1'b1);
    rd(8'h00, 32'h0000_0000, 1'b0);
    rd(8'h28, 32'h0000_0000, 1'b0);
    rd(8'h30, 32'h0000_0000, 1'b0);
    acc(1'b1, 8'h04, 32'hFFFF_FFFE);
    rd(8'h08, 32'h0000_0000, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    $display("reset test done");
    acc(1'b1, 8'h00, 32'h8000_0000);
    rd(8'h00, 32'h8000_0000, 1'b0);
    pins(1'b1, 1'b1, 1'b1);
    acc(1'b1, 8'h00, 32'h0000_0000);
    pins(1'b0, 1'b1, 1'b1);
    acc(1'b1, 8'h04, 32'h0000_0001);
    acc(1'b0, 8'h04, 32'h0000_0000);
    chk(rdat & 32'h0000_0001, 32'h0000_0001);
    pins(1'b0, 1'b0, 1'b1);
    acc(1'b1, 8'h04, 32'h0000_0000);
    pins(1'b0, 1'b1, 1'b1);
    $display("swap and lamp test done");
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h08, 32'h0000_0001 << i);
      acc(1'b0, 8'h08, 32'h0000_0000);
      chk(rdat & 32'h0000_000F, 32'h0000_0001 << i);
      for (int j = 0; j < 4; j++) begin
        {auxRailAlarm, coreRailAlarm, userTempAlarm, overTempAlarm} <= 4'h1 << j;
        pins(1'b0, 1'b1, i != j);
      end
      {auxRailAlarm, coreRailAlarm, userTempAlarm, overTempAlarm} <= 4'h0;
    end
    $display("health lamp test done");
    for (int k = 0; k < 7; k++) begin
      acc(1'b1, 8'h0C + 8'(4 * k), 32'hFFFF_FFFF);
      rd(8'h0C + 8'(4 * k), stat[k], 1'b0);
    end
    $display("status test done");
    acc(1'b1, 8'h28, 32'h0000_0005);
    rd(8'h28, 32'h0000_0005, 1'b0);
    irqSources <= 16'h000F;
    repeat (3) @(posedge clk);
    rd(8'h2C, 32'h0000_000F, 1'b0);
    rd(8'h30, 32'h0000_0005, 1'b0);
    rd(8'h30, 32'h0000_0000, 1'b0);
    irqSources <= 16'h0000;
    $display("interrupt test done");
    acc(1'b1, 8'h34, 32'h0000_0001);
    chk({31'h0, rerr}, 32'h0000_0001);
    rd(8'h3C, 32'h0000_0000, 1'b1);
    rd(8'h00, 32'h0000_0000, 1'b0);
    $display("unmapped test done");
    summarize();
  end
endmodule
